// [hdl/sscm_consts.svh]
`ifndef SSCM_CONSTS_SVH
`define SSCM_CONSTS_SVH
`define SSCM_ADDR_CTRL 4'h0
`define SSCM_ADDR_STATUS 4'h1
`define SSCM_ADDR_MASK 4'h2
`define SSCM_ADDR_LEVEL 4'h3
`define SSCM_ADDR_POP 4'h4
`define SSCM_ADDR_DATA 4'h5
`define SSCM_ADDR_CHAN 4'h6
`define SSCM_ADDR_IDLES 4'h7
`define SSCM_ADDR_FLAGS 4'h8
`define SSCM_ADDR_ERR 4'h9
`define SSCM_ADDR_EMPTY 4'ha
`define SSCM_EV_RDY_ON 0
`define SSCM_EV_RDY_OFF 1
`define SSCM_EV_RX 2
`define SSCM_EV_OVF 3
`define SSCM_EV_W 4
`define SSCM_CTRL_READY 0
`define SSCM_FLAG_SOP 0
`define SSCM_FLAG_EOP 1
`define SSCM_IDLE_MAX 32'hffffffff
`endif

// [hdl/sscm_pkg.sv]
package sscm_pkg;
	typedef struct packed {
		logic [3:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} sscm_bus_type;
endpackage : sscm_pkg

// [hdl/sscm_sink.sv]
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "sscm_consts.svh"
module sscm_sink import sscm_pkg::*; #(
	parameter int USE_PACKETS = 0,
	parameter int USE_CHANNEL = 0,
	parameter int USE_ERROR = 0,
	parameter int USE_READY = 1,
	parameter int USE_VALID = 1,
	parameter int USE_EMPTY = 0,
	parameter int SYMBOL_W = 8,
	parameter int NUM_SYMBOLS = 4,
	parameter int CHANNEL_W = 1,
	parameter int ERROR_W = 1,
	parameter int EMPTY_W = 1,
	parameter int READY_LATENCY = 0,
	parameter int BEATS_PER_CYCLE = 1,
	parameter int DEPTH = 16,
	parameter int PTR_W = 4
) (
	input wire logic MCLK, // 250 MHz clock
	input wire logic RESET_N, // Async reset, low active
	input wire logic CE, // Clock enable
	input wire sscm_bus_type BUS, // Register request
	output logic [31:0] RDATA, // Read data, one cycle after read
	output logic IRQ, // Level interrupt
	output logic READY, // Stream ready
	input wire logic VALID, // Stream valid
	input wire logic [SYMBOL_W*NUM_SYMBOLS*BEATS_PER_CYCLE-1:0] DATA, // Stream data
	input wire logic [CHANNEL_W-1:0] CHANNEL, // Channel id
	input wire logic [ERROR_W-1:0] ERROR, // Error bits
	input wire logic SOP, // Start of packet
	input wire logic EOP, // End of packet
	input wire logic [EMPTY_W-1:0] EMPTY // Empty symbol count
);
	localparam int DW = SYMBOL_W * NUM_SYMBOLS * BEATS_PER_CYCLE;
	localparam int LW = READY_LATENCY + 1;

	initial begin
		if (SYMBOL_W < 1 || SYMBOL_W > 1024 || NUM_SYMBOLS < 1 || NUM_SYMBOLS > 1024 ||
			CHANNEL_W < 1 || CHANNEL_W > 32 || ERROR_W < 1 || ERROR_W > 1024 ||
			EMPTY_W < 1 || EMPTY_W > 1024 || READY_LATENCY < 0 || READY_LATENCY > 8 ||
			BEATS_PER_CYCLE < 1 || BEATS_PER_CYCLE > 1024 || DW > 32 * 64 ||
			DEPTH != (1 << PTR_W) || PTR_W > 16) begin
			$error("sscm_sink: illegal parameter");
		end
	end

	typedef struct packed {
		logic [DW-1:0] data;
		logic [CHANNEL_W-1:0] chan;
		logic [ERROR_W-1:0] err;
		logic [EMPTY_W-1:0] empty;
		logic sop;
		logic eop;
		logic [31:0] idles;
	} sscm_desc_type;

	typedef struct packed {
		logic ready_cmd;
		logic ready;
		logic [LW-1:0] rdy_hist;
		logic [31:0] idle_cnt;
		logic [`SSCM_EV_W-1:0] status;
		logic [`SSCM_EV_W-1:0] mask;
		logic [PTR_W:0] wptr;
		logic [PTR_W:0] rptr;
		sscm_desc_type cur;
		logic [31:0] rdata;
		logic irq;
	} sscm_state_type;

	sscm_state_type r, next_r;
	sscm_desc_type queue [DEPTH];

	function automatic logic [31:0] word_of(input logic [DW-1:0] d, input logic [31:0] sel);
		logic [DW+31:0] ext;
		ext = {32'h0, d};
		word_of = ext[sel[10:0]*32 +: 32];
	endfunction : word_of

	wire logic [PTR_W:0] level = r.wptr - r.rptr;
	wire logic full = level[PTR_W];
	wire logic vin = (USE_VALID != 0) ? VALID : 1'b1;
	// Bit 0 is ready now, bit n is ready n cycles back
	wire logic [LW:0] ready_line = {r.rdy_hist, r.ready};
	wire logic rdy_ok = (USE_READY != 0) ? ready_line[READY_LATENCY] : 1'b1;
	// no protocol checks: any beat meeting the handshake is kept unless the queue is full
	wire logic take = vin && rdy_ok;
	wire logic push = take && !full;

	sscm_desc_type beat;
	always_comb begin
		beat = '0;
		beat.data = DATA;
		beat.idles = r.idle_cnt;
		if (USE_CHANNEL != 0) beat.chan = CHANNEL;
		if (USE_ERROR != 0) beat.err = ERROR;
		if (USE_PACKETS != 0) begin
			beat.sop = SOP;
			beat.eop = EOP;
			if (USE_EMPTY != 0) beat.empty = EMPTY;
		end
	end

	always_comb begin
		logic [`SSCM_EV_W-1:0] ev;
		logic pop;
		ev = '0;
		pop = 1'b0;
		next_r = r;
		// ready follows the command only with the ready port on
		next_r.ready = (USE_READY != 0) ? r.ready_cmd : 1'b1;
		next_r.rdy_hist = LW'({r.rdy_hist, r.ready});
		ev[`SSCM_EV_RDY_ON] = next_r.ready && !r.ready;
		ev[`SSCM_EV_RDY_OFF] = !next_r.ready && r.ready;
		ev[`SSCM_EV_RX] = push;
		ev[`SSCM_EV_OVF] = take && full;
		if (take) begin
			next_r.idle_cnt = '0;
		end else if (r.idle_cnt != `SSCM_IDLE_MAX) begin
			next_r.idle_cnt = r.idle_cnt + 32'h1;
		end
		if (push) next_r.wptr = r.wptr + 1'b1;
		next_r.rdata = '0;
		if (BUS.wr) begin
			if (BUS.addr == `SSCM_ADDR_CTRL) begin
				next_r.ready_cmd = BUS.wdata[`SSCM_CTRL_READY];
			end else if (BUS.addr == `SSCM_ADDR_MASK) begin
				next_r.mask = BUS.wdata[`SSCM_EV_W-1:0];
			end else if (BUS.addr == `SSCM_ADDR_POP) begin
				pop = level != '0;
			end
		end
		if (BUS.rd) begin
			if (BUS.addr == `SSCM_ADDR_CTRL) begin
				next_r.rdata[`SSCM_CTRL_READY] = r.ready_cmd;
			end else if (BUS.addr == `SSCM_ADDR_STATUS) begin
				next_r.rdata[`SSCM_EV_W-1:0] = r.status;
			end else if (BUS.addr == `SSCM_ADDR_MASK) begin
				next_r.rdata[`SSCM_EV_W-1:0] = r.mask;
			end else if (BUS.addr == `SSCM_ADDR_LEVEL) begin
				next_r.rdata[PTR_W:0] = level;
			end else if (BUS.addr == `SSCM_ADDR_DATA) begin
				next_r.rdata = word_of(r.cur.data, BUS.wdata);
			end else if (BUS.addr == `SSCM_ADDR_CHAN) begin
				next_r.rdata[CHANNEL_W-1:0] = r.cur.chan;
			end else if (BUS.addr == `SSCM_ADDR_IDLES) begin
				next_r.rdata = r.cur.idles;
			end else if (BUS.addr == `SSCM_ADDR_FLAGS) begin
				next_r.rdata[`SSCM_FLAG_SOP] = r.cur.sop;
				next_r.rdata[`SSCM_FLAG_EOP] = r.cur.eop;
			end else if (BUS.addr == `SSCM_ADDR_ERR) begin
				next_r.rdata[(ERROR_W > 32 ? 32 : ERROR_W)-1:0] =
					r.cur.err[(ERROR_W > 32 ? 32 : ERROR_W)-1:0];
			end else if (BUS.addr == `SSCM_ADDR_EMPTY) begin
				next_r.rdata[(EMPTY_W > 32 ? 32 : EMPTY_W)-1:0] =
					r.cur.empty[(EMPTY_W > 32 ? 32 : EMPTY_W)-1:0];
			end
		end
		if (pop) begin
			next_r.cur = queue[r.rptr[PTR_W-1:0]];
			next_r.rptr = r.rptr + 1'b1;
		end
		// Read clears the status, but a new event in the same cycle wins
		if (BUS.rd && BUS.addr == `SSCM_ADDR_STATUS) next_r.status = ev;
		else next_r.status = r.status | ev;
		next_r.irq = |(next_r.status & next_r.mask);
	end

	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			r <= '0;
		end else if (CE) begin
			r <= next_r;
		end
	end

	always_ff @(posedge MCLK) begin
		if (CE && push) begin
			queue[r.wptr[PTR_W-1:0]] <= beat;
		end
	end

	assign RDATA = r.rdata;
	assign IRQ = r.irq;
	assign READY = r.ready;

	a_rdy_follow: assert property (@(posedge MCLK) disable iff (!RESET_N)
		(CE && USE_READY != 0)
		|=> READY == $past(r.ready_cmd))
		else $error("ready did not follow command");

	a_rdy_forced: assert property (@(posedge MCLK) disable iff (!RESET_N)
		(CE && USE_READY == 0)
		|=> READY)
		else $error("ready not held without ready port");

	a_rdy_on_event: assert property (@(posedge MCLK) disable iff (!RESET_N)
		(CE && $rose(READY))
		|-> r.status[`SSCM_EV_RDY_ON])
		else $error("ready rise event missing");

	a_rdy_off_event: assert property (@(posedge MCLK) disable iff (!RESET_N)
		(CE && $fell(READY))
		|-> r.status[`SSCM_EV_RDY_OFF])
		else $error("ready fall event missing");

	a_push_rx: assert property (@(posedge MCLK) disable iff (!RESET_N)
		(CE && push)
		|=> (r.status[`SSCM_EV_RX] && r.wptr == $past(r.wptr) + 1'b1))
		else $error("captured beat not queued");

	a_capture_gate: assert property (@(posedge MCLK) disable iff (!RESET_N)
		push
		|-> (USE_READY == 0 || ready_line[READY_LATENCY]))
		else $error("capture without ready");

	a_rx_needs_valid: assert property (@(posedge MCLK) disable iff (!RESET_N)
		push
		|-> (USE_VALID == 0 || VALID))
		else $error("capture without valid");

	a_idle_clear: assert property (@(posedge MCLK) disable iff (!RESET_N)
		(CE && take)
		|=> r.idle_cnt == 32'h0)
		else $error("idle count not cleared");

	a_idle_count: assert property (@(posedge MCLK) disable iff (!RESET_N)
		(CE && !take && r.idle_cnt < 32'h10)
		|=> r.idle_cnt == $past(r.idle_cnt) + 32'h1)
		else $error("idle count stuck");

	a_idle_saturate: assert property (@(posedge MCLK) disable iff (!RESET_N)
		(CE && !take && r.idle_cnt == `SSCM_IDLE_MAX)
		|=> r.idle_cnt == `SSCM_IDLE_MAX)
		else $error("idle count wrapped");

	a_irq_level: assert property (@(posedge MCLK) disable iff (!RESET_N)
		1'b1
		|-> IRQ == |(r.status & r.mask))
		else $error("interrupt level wrong");

	a_ce_freeze: assert property (@(posedge MCLK) disable iff (!RESET_N)
		!CE
		|=> $stable(r))
		else $error("state moved with clock enable low");

	a_ovf_event: assert property (@(posedge MCLK) disable iff (!RESET_N)
		(CE && take && full)
		|=> r.status[`SSCM_EV_OVF])
		else $error("overflow event missing");

	a_no_push_full: assert property (@(posedge MCLK) disable iff (!RESET_N)
		full
		|-> !push)
		else $error("push into full queue");

	a_level_bound: assert property (@(posedge MCLK) disable iff (!RESET_N)
		1'b1
		|-> level <= DEPTH)
		else $error("queue level beyond depth");

	a_wptr_hold: assert property (@(posedge MCLK) disable iff (!RESET_N)
		(CE && !push)
		|=> r.wptr == $past(r.wptr))
		else $error("write pointer moved without capture");

	a_pop_advance: assert property (@(posedge MCLK) disable iff (!RESET_N)
		(CE && BUS.wr && BUS.addr == `SSCM_ADDR_POP && level != '0)
		|=> r.rptr == $past(r.rptr) + 1'b1)
		else $error("pop did not advance");

	a_pop_empty: assert property (@(posedge MCLK) disable iff (!RESET_N)
		(CE && BUS.wr && BUS.addr == `SSCM_ADDR_POP && level == '0)
		|=> r.rptr == $past(r.rptr))
		else $error("pop on empty queue moved pointer");

	a_cur_hold: assert property (@(posedge MCLK) disable iff (!RESET_N)
		(CE && !(BUS.wr && BUS.addr == `SSCM_ADDR_POP))
		|=> $stable(r.cur))
		else $error("current descriptor changed without pop");

	a_illegal_kept: assert property (@(posedge MCLK) disable iff (!RESET_N)
		(CE && push && USE_PACKETS != 0 && EOP && !SOP)
		|=> r.status[`SSCM_EV_RX])
		else $error("illegal beat not queued");

	a_rdata_idle: assert property (@(posedge MCLK) disable iff (!RESET_N)
		(CE && !BUS.rd)
		|=> RDATA == 32'h0)
		else $error("read data without read");

	a_status_read: assert property (@(posedge MCLK) disable iff (!RESET_N)
		(CE && BUS.rd && BUS.addr == `SSCM_ADDR_STATUS)
		|=> RDATA[`SSCM_EV_W-1:0] == $past(r.status))
		else $error("status read wrong");

	a_status_clear: assert property (@(posedge MCLK) disable iff (!RESET_N)
		(CE && BUS.rd && BUS.addr == `SSCM_ADDR_STATUS && !take &&
			READY == ((USE_READY != 0) ? r.ready_cmd : 1'b1))
		|=> r.status == '0)
		else $error("status not cleared by read");

	a_mask_write: assert property (@(posedge MCLK) disable iff (!RESET_N)
		(CE && BUS.wr && BUS.addr == `SSCM_ADDR_MASK)
		|=> r.mask == $past(BUS.wdata[`SSCM_EV_W-1:0]))
		else $error("mask write lost");

	a_mask_read: assert property (@(posedge MCLK) disable iff (!RESET_N)
		(CE && BUS.rd && BUS.addr == `SSCM_ADDR_MASK)
		|=> RDATA[`SSCM_EV_W-1:0] == $past(r.mask))
		else $error("mask read wrong");

	a_ctrl_write: assert property (@(posedge MCLK) disable iff (!RESET_N)
		(CE && BUS.wr && BUS.addr == `SSCM_ADDR_CTRL)
		|=> r.ready_cmd == $past(BUS.wdata[`SSCM_CTRL_READY]))
		else $error("ready command write lost");

	a_level_read: assert property (@(posedge MCLK) disable iff (!RESET_N)
		(CE && BUS.rd && BUS.addr == `SSCM_ADDR_LEVEL)
		|=> RDATA[PTR_W:0] == $past(level))
		else $error("level read wrong");

	a_chan_read: assert property (@(posedge MCLK) disable iff (!RESET_N)
		(CE && BUS.rd && BUS.addr == `SSCM_ADDR_CHAN)
		|=> RDATA[CHANNEL_W-1:0] == $past(r.cur.chan))
		else $error("channel read wrong");

	a_idles_read: assert property (@(posedge MCLK) disable iff (!RESET_N)
		(CE && BUS.rd && BUS.addr == `SSCM_ADDR_IDLES)
		|=> RDATA == $past(r.cur.idles))
		else $error("idle count read wrong");

	a_flags_read: assert property (@(posedge MCLK) disable iff (!RESET_N)
		(CE && BUS.rd && BUS.addr == `SSCM_ADDR_FLAGS)
		|=> (RDATA[`SSCM_FLAG_EOP] == $past(r.cur.eop) && RDATA[`SSCM_FLAG_SOP] == $past(r.cur.sop)))
		else $error("packet flags read wrong");

	a_no_pkt_flags: assert property (@(posedge MCLK) disable iff (!RESET_N)
		(USE_PACKETS == 0)
		|-> (!beat.sop && !beat.eop))
		else $error("packet flags without packet option");

	a_empty_off: assert property (@(posedge MCLK) disable iff (!RESET_N)
		(USE_PACKETS == 0 || USE_EMPTY == 0)
		|-> beat.empty == '0)
		else $error("empty captured without empty port");

	a_no_chan: assert property (@(posedge MCLK) disable iff (!RESET_N)
		(USE_CHANNEL == 0)
		|-> beat.chan == '0)
		else $error("channel captured without channel port");

	a_err_off: assert property (@(posedge MCLK) disable iff (!RESET_N)
		(USE_ERROR == 0)
		|-> beat.err == '0)
		else $error("error captured without error port");

	generate
		for (genvar i = 0; i < `SSCM_EV_W; i++) begin : g_sticky
			a_status_sticky: assert property (@(posedge MCLK) disable iff (!RESET_N)
				(CE && r.status[i] && !(BUS.rd && BUS.addr == `SSCM_ADDR_STATUS))
				|=> r.status[i])
				else $error("status bit lost");
		end
	endgenerate

	c_capture: cover property (@(posedge MCLK) push);
	c_illegal: cover property (@(posedge MCLK) push && EOP && !SOP);
	c_full: cover property (@(posedge MCLK) take && full);
	c_pop: cover property (@(posedge MCLK) BUS.wr && BUS.addr == `SSCM_ADDR_POP && level != '0);
	c_backpressure: cover property (@(posedge MCLK) $fell(READY));
endmodule : sscm_sink
`default_nettype wire

// [tb/sscm_src_model.sv]
`timescale 1ns/1ps
`default_nettype none
module sscm_src_model (
	input wire logic clk, // Stream clock
	input wire logic ready, // Sink ready
	input wire logic go, // Pulse: offer one beat
	input wire logic [38:0] beat, // empty, chan, sop, eop, data
	output logic valid, // Beat valid
	output logic [38:0] lines // Beat fields on the wire
);
	initial begin
		valid = 1'b0;
		lines = '0;
	end
	// Holds the beat until ready is seen at an edge; latency zero
	always @(posedge clk) begin
		if (go) begin
			valid <= 1'b1;
			lines <= beat;
		end else if (valid && ready) begin
			valid <= 1'b0;
			// Released lines flip so a stale capture cannot pass
			lines <= ~lines;
		end
	end
endmodule : sscm_src_model
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sscm_consts.svh"
module tb import sscm_pkg::*;;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic go = 1'b0;
	logic src_valid, rdy, irq;
	sscm_bus_type bus = '0;
	logic [31:0] rdata;
	logic [38:0] beat = '0;
	logic [38:0] lines;
	logic [38:0] rows [4];
	logic [31:0] row_idles [4];
	logic ce = 1'b1;
	int n_mismatch = 0;
	int samples_checked = 0;
	int cyc = 0;
	sscm_sink #(.USE_PACKETS(1), .USE_CHANNEL(1), .USE_EMPTY(1), .CHANNEL_W(4)) dut_u (
		.MCLK(mclk), .RESET_N(reset_n), .CE(ce), .BUS(bus), .RDATA(rdata), .IRQ(irq),
		.READY(rdy), .VALID(src_valid), .DATA(lines[31:0]), .CHANNEL(lines[37:34]),
		.ERROR(1'b0), .SOP(lines[33]), .EOP(lines[32]), .EMPTY(lines[38]));
	sscm_src_model src_u (.clk(mclk), .ready(rdy), .go(go), .beat(beat), .valid(src_valid),
		.lines(lines));
	always #2 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_mismatch++;
			end_of_test();
		end
	end
	task end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : end_of_test
	task chk(string nm, logic [31:0] exp, logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task wr(logic [3:0] a, logic [31:0] d);
		@(posedge mclk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		bus <= '0;
	endtask : wr
	// Read data stands only in the cycle after the strobe
	task rd(logic [3:0] a, string nm, logic [31:0] exp);
		@(posedge mclk);
		bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge mclk);
		bus <= '0;
		#1 chk(nm, exp, rdata);
	endtask : rd
	task settle(int n);
		repeat (n) begin
			@(posedge mclk);
			#1;
			if (!src_valid) break;
		end
	endtask : settle
	task send(logic [38:0] b, int n);
		@(posedge mclk);
		beat <= b;
		go <= 1'b1;
		@(posedge mclk);
		go <= 1'b0;
		settle(n);
	endtask : send
	task pop_chk(logic [38:0] b, logic [31:0] idl);
		wr(`SSCM_ADDR_POP, 32'h0);
		rd(`SSCM_ADDR_DATA, "data", b[31:0]);
		rd(`SSCM_ADDR_CHAN, "chan", {28'h0, b[37:34]});
		rd(`SSCM_ADDR_FLAGS, "flags", {30'h0, b[32], b[33]});
		rd(`SSCM_ADDR_EMPTY, "empty", {31'h0, b[38]});
		rd(`SSCM_ADDR_IDLES, "idles", idl);
	endtask : pop_chk
	initial begin
		// Eop without sop is illegal yet must still be queued
		rows = '{{1'b0, 4'h3, 1'b1, 1'b0, 32'h0123abcd}, {1'b1, 4'hf, 1'b0, 1'b1, 32'hffff0000},
			{1'b0, 4'h0, 1'b0, 1'b1, 32'h00000001}, {1'b1, 4'ha, 1'b1, 1'b1, 32'h5a5a5a5a}};
		// Quiet cycles since reset for the first beat, four between later ones
		row_idles = '{32'h0000000b, 32'h00000004, 32'h00000004, 32'h00000004};
		repeat (10) @(posedge mclk);
		reset_n <= 1'b1;
		#1 chk("ready", 32'h0, {31'h0, rdy});
		chk("irq", 32'h0, {31'h0, irq});
		wr(`SSCM_ADDR_MASK, 32'hf);
		wr(`SSCM_ADDR_CTRL, 32'h1);
		repeat (3) @(posedge mclk);
		#1 chk("ready", 32'h1, {31'h0, rdy});
		chk("irq", 32'h1, {31'h0, irq});
		rd(`SSCM_ADDR_STATUS, "status", 32'h1);
		for (int i = 0; i < 4; i++) begin
			send(rows[i], 20);
			rd(`SSCM_ADDR_LEVEL, "level", i + 1);
		end
		rd(`SSCM_ADDR_STATUS, "status", 32'h4);
		for (int i = 0; i < 4; i++) pop_chk(rows[i], row_idles[i]);
		rd(`SSCM_ADDR_LEVEL, "level", 32'h0);
		$display("table test done");
		wr(`SSCM_ADDR_CTRL, 32'h0);
		repeat (3) @(posedge mclk);
		#1 chk("ready", 32'h0, {31'h0, rdy});
		rd(`SSCM_ADDR_STATUS, "status", 32'h2);
		send(rows[1], 10);
		chk("held valid", 32'h1, {31'h0, src_valid});
		rd(`SSCM_ADDR_LEVEL, "level", 32'h0);
		wr(`SSCM_ADDR_CTRL, 32'h1);
		settle(20);
		rd(`SSCM_ADDR_LEVEL, "level", 32'h1);
		// Cycles stalled by back pressure count as idle as well
		pop_chk(rows[1], 32'h0000004e);
		$display("back pressure test done");
		wr(`SSCM_ADDR_MASK, 32'h0);
		repeat (2) @(posedge mclk);
		#1 chk("masked irq", 32'h0, {31'h0, irq});
		rd(`SSCM_ADDR_STATUS, "status", 32'h5);
		rd(4'hf, "unmapped", 32'h0);
		wr(`SSCM_ADDR_POP, 32'h0);
		rd(`SSCM_ADDR_LEVEL, "level", 32'h0);
		$display("mask and refusal test done");
		@(posedge mclk) ce <= 1'b0;
		wr(`SSCM_ADDR_CTRL, 32'h0);
		repeat (3) @(posedge mclk);
		#1 chk("frozen ready", 32'h1, {31'h0, rdy});
		@(posedge mclk) ce <= 1'b1;
		rd(`SSCM_ADDR_CTRL, "ctrl", 32'h1);
		$display("clock enable test done");
		end_of_test();
	end
endmodule : tb
`default_nettype wire
